// ==== core_timing_pkg.sv ====
// Shared constants and types for the instruction timing core
//------------------------------------------------------------
// What this block does
//------------------------------------------------------------
// What this block does
// RQ1: Decode all opcodes with standard encoding
// RQ2: Time everything in plain system clock cycles
// RQ3: No instruction exceeds eight clock cycles
// RQ4: Most instructions: cycles equal byte count
// RQ5: Untaken conditional branch finishes one cycle sooner
// RQ6: Timing table covers all 109 instructions
// RQ7: Peak one instruction per clock
// RQ8: Add register to accumulator: 1 byte, 1 cycle
// RQ9: Add direct byte: 2 bytes, 2 cycles
// RQ10: Add indirect byte: 1 byte, 2 cycles
// RQ11: Add immediate: 2 bytes, 2 cycles
// RQ12: Subtract register with borrow: 1 byte, 1 cycle
// RQ13: Subtract direct byte with borrow: 2 bytes, 2 cycles
// RQ14: Subtract indirect byte with borrow: 1 byte, 2 cycles
// RQ15: Subtract immediate with borrow: 2 bytes, 2 cycles
// RQ16: External data move routed to three targets
// RQ17: Software reads and writes flash bytewise
// RQ18: Serial test port programs flash, reaches debug (no test port here; debug halt, run and step arrive on input pins)
// RQ19: Breakpoints, watchpoints, run, stop, single step
// RQ20: Debug uses no user resources
// RQ21: Arithmetic sets carry, aux carry, overflow
package core_timing_pkg;

    localparam logic [3:0]  MAX_CYCLES      = 4'h8;
    localparam logic [3:0]  ONE_CYCLE       = 4'h1;
    localparam logic [3:0]  TWO_CYCLES      = 4'h2;
    localparam logic [3:0]  MOVE_CYCLES     = 4'h3;
    localparam logic [3:0]  MUL_CYCLES      = 4'h4;
    localparam logic [3:0]  RET_CYCLES      = 4'h5;

    localparam logic [7:0]  OP_ADD_BASE     = 8'h24;
    localparam logic [7:0]  OP_ADD_WITH_CARRY_BASE    = 8'h34;
    localparam logic [7:0]  OP_SUBTRACT_WITH_BORROW_BASE    = 8'h94;
    localparam logic [7:0]  OP_MUL          = 8'hA4;
    localparam logic [7:0]  OP_DIV          = 8'h84;
    localparam logic [7:0]  OP_CODE_MOVE_DP = 8'h93;
    localparam logic [7:0]  OP_CODE_MOVE_PC = 8'h83;
    localparam logic [7:0]  OP_RET          = 8'h22;
    localparam logic [7:0]  OP_RETI         = 8'h32;
    localparam logic [7:0]  OP_LJMP         = 8'h02;
    localparam logic [7:0]  OP_LCALL        = 8'h12;
    localparam logic [7:0]  OP_JMP_IND      = 8'h73;

    localparam logic [15:0] EXPANSION_RAM_ONCHIP_TOP = 16'h1000;
    localparam int          PSW_CY          = 7;
    localparam int          PSW_AC          = 6;
    localparam int          PSW_OV          = 2;
    localparam int          PSW_P           = 0;
    localparam logic [7:0]  PSW_RESET       = 8'h00;
    localparam logic [7:0]  ACC_RESET       = 8'h00;

    typedef enum logic [1:0] {
        TGT_EXPANSION_RAM_ON  = 2'b00,
        TGT_EXPANSION_RAM_OFF = 2'b01,
        TGT_FLASH    = 2'b10,
        TGT_NONE     = 2'b11
    } xdm_target_t;

    typedef enum logic [1:0] {
        ARITH_ADD  = 2'b00,
        ARITH_ADD_WITH_CARRY = 2'b01,
        ARITH_SUBTRACT_WITH_BORROW = 2'b10
    } arith_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_HALT = 2'b10
    } core_state_t;

    typedef enum logic [1:0] {
        HALT_NONE  = 2'b00,
        HALT_REQ   = 2'b01,
        HALT_BREAK = 2'b10,
        HALT_WATCH = 2'b11
    } halt_cause_t;

endpackage

// ==== cpu_arith_unit.sv ====
// Add, add with carry and subtract with borrow with flag results
`timescale 1ns/100ps
module cpu_arith_unit
    import core_timing_pkg::*;
(
    input  wire logic [7:0] acc_in,
    input  wire logic [7:0] operand,
    input  wire logic       carry_in,
    input  wire arith_op_t  op_sel,
    output logic      [7:0] result,
    output logic            carry_out,
    output logic            aux_carry_out,
    output logic            overflow_out
);

    // Subtraction is a - b - c done directly so borrow reads off bit 8
    wire        is_sub  = (op_sel == ARITH_SUBTRACT_WITH_BORROW);
    wire        cin     = (op_sel == ARITH_ADD) ? 1'b0 : carry_in;
    wire [8:0]  full_add = {1'b0, acc_in} + {1'b0, operand} + {8'h00, cin};
    wire [8:0]  full_sub = {1'b0, acc_in} - {1'b0, operand} - {8'h00, cin};
    wire [4:0]  low_add  = {1'b0, acc_in[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
    wire [4:0]  low_sub  = {1'b0, acc_in[3:0]} - {1'b0, operand[3:0]} - {4'h0, cin};
    wire [8:0]  full     = is_sub ? full_sub : full_add;

    assign result        = full[7:0];
    assign carry_out     = full[8]; // RQ21
    assign aux_carry_out = is_sub ? low_sub[4] : low_add[4]; // RQ21
    // Overflow: signed operands agree (add) or differ (sub) and sign flips
    assign overflow_out  = is_sub ? ((acc_in[7] != operand[7]) && (full[7] != acc_in[7])) // RQ21
                                  : ((acc_in[7] == operand[7]) && (full[7] != acc_in[7]));

endmodule

// ==== cpu_core_instruction_timing.sv ====
// Instruction timing sequencer, arithmetic execute, data move routing and run control
`timescale 1ns/100ps
module cpu_core_instruction_timing
    import core_timing_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        issue_valid,
    input  wire logic [7:0]  issue_opcode,
    input  wire logic [7:0]  issue_operand1,
    input  wire logic [15:0] issue_pc,
    input  wire logic        issue_branch_taken,
    input  wire logic [7:0]  operand_data,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic [15:0] dptr,
    input  wire logic [7:0]  xdm_page,
    input  wire logic        flash_read_enable,
    input  wire logic        flash_write_enable,
    input  wire logic        dbg_halt_req,
    input  wire logic        dbg_run_req,
    input  wire logic        dbg_step_req,
    input  wire logic        bp_enable,
    input  wire logic [15:0] bp_addr,
    input  wire logic        wp_enable,
    input  wire logic [15:0] wp_addr,
    output logic             issue_ready,
    output logic             instr_done,
    output logic [1:0]       done_bytes,
    output logic [3:0]       done_cycles,
    output logic [7:0]       acc,
    output logic [7:0]       program_status_word,
    output logic [1:0]       xdm_target,
    output logic             xdm_rd,
    output logic             xdm_wr,
    output logic [15:0]      xdm_addr,
    output logic [7:0]       xdm_wdata,
    output logic             code_rd,
    output logic [15:0]      code_addr,
    output logic             halted,
    output logic [1:0]       halt_cause
);

    //------------------------------------------------------------
    // Decode functions
    //------------------------------------------------------------
    // Byte count from the opcode map; the fetch side supplies the bytes themselves
    function automatic logic [1:0] instr_bytes(input logic [7:0] op); // RQ1
        logic [3:0] hi;
        hi = op[7:4];
        case (op[3:0])
            4'h0:
                instr_bytes = (hi inside {4'h1, 4'h2, 4'h3, 4'h9}) ? 2'd3 : ((hi != 4'h0 && hi < 4'hE) ? 2'd2 : 2'd1);
            4'h1:
                instr_bytes = 2'd2;
            4'h2:
                instr_bytes = (op == OP_LJMP || op == OP_LCALL) ? 2'd3 : ((hi >= 4'h4 && hi <= 4'hD) ? 2'd2 : 2'd1);
            4'h3:
                instr_bytes = (hi >= 4'h4 && hi <= 4'h6) ? 2'd3 : 2'd1;
            4'h4:
                instr_bytes = (hi == 4'hB) ? 2'd3 : ((hi inside {[4'h2:4'h7], 4'h9}) ? 2'd2 : 2'd1);
            4'h5:
                instr_bytes = (hi inside {4'h7, 4'h8, 4'hB, 4'hD}) ? 2'd3 : ((hi != 4'hA) ? 2'd2 : 2'd1);
            4'h6, 4'h7:
                instr_bytes = (hi == 4'hB) ? 2'd3 : ((hi inside {4'h7, 4'h8, 4'hA}) ? 2'd2 : 2'd1);
            default:
                instr_bytes = (hi == 4'hB) ? 2'd3 : ((hi inside {4'h7, 4'h8, 4'hA, 4'hD}) ? 2'd2 : 2'd1);
        endcase
    endfunction

    function automatic logic is_cond_branch(input logic [7:0] op);
        is_cond_branch = (op[3:0] == 4'h0 && op[7:4] >= 4'h1 && op[7:4] <= 4'h7)
                      || (op[7:4] == 4'hB && op[3:2] != 2'b00)
                      || (op[7:4] == 4'hD && (op[3:0] == 4'h5 || op[3]))
                      || (op == 8'hB4);
    endfunction

    function automatic logic is_xdm(input logic [7:0] op);
        is_xdm = (op[7:5] == 3'b111) && (op[3:0] == 4'h0 || op[3:1] == 3'b001);
    endfunction

    // Cycle count for the taken path; untaken branches subtract one later
    function automatic logic [3:0] cycles_taken(input logic [7:0] op); // RQ6
        logic [3:0] c;
        c = {2'b00, instr_bytes(op)}; // RQ4
        if (op == OP_DIV) begin
            c = MAX_CYCLES; // RQ3
        end else if (op == OP_MUL) begin
            c = MUL_CYCLES;
        end else if (is_xdm(op) || op == OP_CODE_MOVE_DP || op == OP_CODE_MOVE_PC) begin
            c = MOVE_CYCLES;
        end else if (op == OP_RET || op == OP_RETI) begin
            c = RET_CYCLES;
        end else if (op[3:0] == 4'h1 || op == OP_JMP_IND || op == 8'h80) begin
            c = MOVE_CYCLES;
        end else if (op == OP_LJMP || op == OP_LCALL) begin
            c = MUL_CYCLES;
        end else if ((op[3:1] == 3'b011) && instr_bytes(op) == 2'd1) begin
            c = TWO_CYCLES; // RQ10 RQ14
        end
        if (is_cond_branch(op)) begin
            c = c + ONE_CYCLE;
            if (op[7:4] == 4'hB && op[3:1] == 3'b011) begin
                c = c + ONE_CYCLE;
            end
        end
        cycles_taken = c;
    endfunction

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    core_state_t state_reg;
    core_state_t state_next;
    logic [7:0]  op_reg;
    logic [7:0]  op1_reg;
    logic [15:0] pc_reg;
    logic        taken_reg;
    logic        pend_reg;
    logic        step_reg;
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_next;
    logic        cy_reg;
    logic        ac_reg;
    logic        ov_reg;
    logic [7:0]  acc_reg;
    logic [15:0] mv_addr_reg;
    logic        mv_is_wr_reg;

    //------------------------------------------------------------
    // Selection of the instruction being launched or finished
    //------------------------------------------------------------
    // In idle the inputs are used directly so one-cycle ops run back to back
    wire         in_idle    = (state_reg == ST_IDLE);
    wire         accept     = in_idle && issue_valid && issue_ready; // RQ7
    wire [7:0]   cur_op     = in_idle ? issue_opcode : op_reg;
    wire [7:0]   cur_op1    = in_idle ? issue_operand1 : op1_reg;
    wire [15:0]  cur_pc     = in_idle ? issue_pc : pc_reg;
    wire         cur_taken  = in_idle ? issue_branch_taken : taken_reg;
    wire         cur_cond   = is_cond_branch(cur_op);
    wire [3:0]   cur_cycles = cycles_taken(cur_op) - {3'b000, cur_cond && !cur_taken}; // RQ5 RQ2
    wire [1:0]   cur_bytes  = instr_bytes(cur_op);

    wire         bp_hit     = bp_enable && (issue_pc == bp_addr) && !step_reg; // RQ19
    wire         resume     = (state_reg == ST_HALT) && (dbg_run_req || dbg_step_req); // RQ19
    wire         launch     = (accept && !bp_hit) || (resume && pend_reg);
    wire         commit     = (launch && cur_cycles == ONE_CYCLE)
                           || (state_reg == ST_EXEC && cnt_reg == 4'h0);

    //------------------------------------------------------------
    // Arithmetic group
    //------------------------------------------------------------
    wire         grp_add    = (cur_op[7:4] == OP_ADD_BASE[7:4]) && (cur_op[3:2] != 2'b00 || cur_op[1:0] == 2'b00);
    wire         grp_add_with_carry   = (cur_op[7:4] == OP_ADD_WITH_CARRY_BASE[7:4]) && (cur_op[3:2] != 2'b00 || cur_op[1:0] == 2'b00);
    wire         grp_subtract_with_borrow   = (cur_op[7:4] == OP_SUBTRACT_WITH_BORROW_BASE[7:4]) && (cur_op[3:2] != 2'b00 || cur_op[1:0] == 2'b00);
    wire         is_arith   = grp_add || grp_add_with_carry || grp_subtract_with_borrow;
    // Column 4 is the immediate form, the byte comes from the fetch stream
    wire [7:0]   arith_src  = (cur_op[3:0] == 4'h4) ? cur_op1 : operand_data; // RQ11 RQ15
    wire         arith_op_add  = grp_add;
    wire         arith_op_add_with_carry = grp_add_with_carry;
    arith_op_t   arith_sel;
    assign arith_sel = arith_op_add ? ARITH_ADD : (arith_op_add_with_carry ? ARITH_ADD_WITH_CARRY : ARITH_SUBTRACT_WITH_BORROW);

    wire [7:0]   arith_res;
    wire         arith_cy;
    wire         arith_ac;
    wire         arith_ov;

    cpu_arith_unit u_arith (
        .acc_in        (acc_reg),
        .operand       (arith_src),
        .carry_in      (cy_reg),
        .op_sel        (arith_sel),
        .result        (arith_res),
        .carry_out     (arith_cy),
        .aux_carry_out (arith_ac),
        .overflow_out  (arith_ov)
    );

    //------------------------------------------------------------
    // External data move routing and flash byte access
    //------------------------------------------------------------
    wire         cur_xdm    = is_xdm(cur_op);
    wire         cur_xdm_wr = cur_op[4];
    // Columns 2 and 3 use the 8-bit register address on the current page
    wire [15:0]  cur_xaddr  = (cur_op[3:0] == 4'h0) ? dptr : {xdm_page, operand_data};
    wire         to_flash   = cur_xdm_wr ? flash_write_enable : flash_read_enable;
    wire [1:0]   route      = to_flash ? TGT_FLASH
                            : (cur_xaddr < EXPANSION_RAM_ONCHIP_TOP) ? TGT_EXPANSION_RAM_ON : TGT_EXPANSION_RAM_OFF; // RQ16 RQ17
    wire         cur_code   = (cur_op == OP_CODE_MOVE_DP) || (cur_op == OP_CODE_MOVE_PC);
    wire [15:0]  pc_after   = cur_pc + 16'h0001;
    wire [15:0]  code_base  = (cur_op == OP_CODE_MOVE_DP) ? dptr : pc_after;
    wire [15:0]  cur_caddr  = code_base + {8'h00, acc_reg}; // RQ17

    wire         wp_hit     = wp_enable && (state_reg == ST_EXEC) && commit
                           && is_xdm(op_reg) && (mv_addr_reg == wp_addr); // RQ19
    wire [7:0]   acc_commit = is_arith ? arith_res
                            : ((cur_xdm && !mv_is_wr_reg) || cur_code) ? mem_rdata : acc_reg;

    //------------------------------------------------------------
    // Sequencer
    //------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                if (dbg_halt_req) begin
                    state_next = ST_HALT;
                end else if (accept && bp_hit) begin
                    state_next = ST_HALT;
                end else if (launch && cur_cycles != ONE_CYCLE) begin
                    state_next = ST_EXEC;
                    cnt_next   = cur_cycles - TWO_CYCLES;
                end else if (commit && step_reg) begin
                    state_next = ST_HALT;
                end
            end
            ST_EXEC: begin
                cnt_next = cnt_reg - 4'h1;
                if (commit) begin
                    state_next = (step_reg || wp_hit || dbg_halt_req) ? ST_HALT : ST_IDLE;
                end
            end
            ST_HALT: begin
                if (launch && cur_cycles != ONE_CYCLE) begin
                    state_next = ST_EXEC;
                    cnt_next   = cur_cycles - TWO_CYCLES;
                end else if (resume && !(launch && dbg_step_req)) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Run control lives in its own flops so no user state is touched
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg   <= ST_IDLE;
            cnt_reg     <= 4'h0;
            issue_ready <= 1'b0;
            halted      <= 1'b0;
            halt_cause  <= HALT_NONE;
            pend_reg    <= 1'b0;
            step_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            issue_ready <= (state_next == ST_IDLE) && !(step_reg && commit); // RQ7
            halted      <= (state_next == ST_HALT); // RQ19 RQ20
            if (state_reg != ST_HALT && state_next == ST_HALT) begin
                halt_cause <= (accept && bp_hit) ? HALT_BREAK : (wp_hit ? HALT_WATCH : HALT_REQ);
            end
            if (accept && bp_hit) begin
                pend_reg <= 1'b1;
            end else if (launch) begin
                pend_reg <= 1'b0;
            end
            // A step lets exactly one instruction through, past any breakpoint
            if (resume) begin
                step_reg <= dbg_step_req && !dbg_run_req;
            end else if (commit) begin
                step_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (accept) begin
            op_reg    <= issue_opcode;
            op1_reg   <= issue_operand1;
            pc_reg    <= issue_pc;
            taken_reg <= issue_branch_taken;
        end
        if (launch) begin
            mv_addr_reg  <= cur_xaddr;
            mv_is_wr_reg <= cur_xdm_wr;
        end
    end

    //------------------------------------------------------------
    // Architectural results and memory strobes
    //------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            acc_reg             <= ACC_RESET;
            cy_reg              <= PSW_RESET[PSW_CY];
            ac_reg              <= PSW_RESET[PSW_AC];
            ov_reg              <= PSW_RESET[PSW_OV];
            program_status_word <= PSW_RESET;
            instr_done          <= 1'b0;
            done_bytes          <= 2'd0;
            done_cycles         <= 4'h0;
        end else begin
            instr_done <= commit;
            if (commit) begin
                acc_reg     <= acc_commit;
                done_bytes  <= cur_bytes;
                done_cycles <= cur_cycles;
                program_status_word[PSW_P] <= ^acc_commit;
                if (is_arith) begin
                    cy_reg <= arith_cy; // RQ21 RQ8 RQ9 RQ12 RQ13
                    ac_reg <= arith_ac;
                    ov_reg <= arith_ov;
                    program_status_word[PSW_CY] <= arith_cy;
                    program_status_word[PSW_AC] <= arith_ac;
                    program_status_word[PSW_OV] <= arith_ov;
                end
            end
        end
    end

    assign acc = acc_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            xdm_target <= TGT_NONE;
            xdm_rd     <= 1'b0;
            xdm_wr     <= 1'b0;
            xdm_addr   <= 16'h0000;
            xdm_wdata  <= 8'h00;
            code_rd    <= 1'b0;
            code_addr  <= 16'h0000;
        end else begin
            xdm_rd  <= launch && cur_xdm && !cur_xdm_wr;
            xdm_wr  <= launch && cur_xdm && cur_xdm_wr;
            code_rd <= launch && cur_code;
            if (launch && cur_xdm) begin
                xdm_target <= route; // RQ16
                xdm_addr   <= cur_xaddr;
                xdm_wdata  <= acc_reg;
            end
            if (launch && cur_code) begin
                code_addr <= cur_caddr;
            end
        end
    end

endmodule

// ==== cit_chk.sv ====
// Port-level checks for the instruction timing core
`timescale 1ns/100ps
module cit_chk
    import core_timing_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        issue_valid,
    input wire logic [7:0]  issue_opcode,
    input wire logic [15:0] issue_pc,
    input wire logic        issue_branch_taken,
    input wire logic        flash_read_enable,
    input wire logic        bp_enable,
    input wire logic [15:0] bp_addr,
    input wire logic        issue_ready,
    input wire logic        instr_done,
    input wire logic [1:0]  done_bytes,
    input wire logic [3:0]  done_cycles,
    input wire logic [1:0]  xdm_target,
    input wire logic        xdm_rd,
    input wire logic        halted,
    input wire logic [1:0]  halt_cause
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire       bp_hit = bp_enable && bp_addr == issue_pc;
    wire       take   = issue_valid && issue_ready && !bp_hit;
    wire [7:0] op     = issue_opcode;
    wire       arith  = op[7:4] inside {4'h2, 4'h3, 4'h9};
    AST_REG_ONE_CLK: assert property (
        take && arith && op[3] |=> instr_done && issue_ready && done_cycles == 4'h1 && done_bytes == 2'h1)
        else $error("register timing");
    AST_IMM_TWO: assert property (
        take && arith && op[3:0] == 4'h4 |=> !instr_done ##1 instr_done && done_cycles == 4'h2 && done_bytes == 2'h2)
        else $error("immediate timing");
    AST_DIRECT_TWO: assert property (
        take && arith && op[3:0] == 4'h5 |=> !instr_done ##1 instr_done && done_cycles == 4'h2 && done_bytes == 2'h2)
        else $error("direct timing");
    AST_INDIRECT_TWO: assert property (
        take && arith && op[3:1] == 3'h3 |=> !instr_done ##1 instr_done && done_cycles == 4'h2 && done_bytes == 2'h1)
        else $error("indirect timing");
    AST_BRANCH_SKIP: assert property (
        take && op == 8'h60 && !issue_branch_taken |=> !instr_done ##1 instr_done && done_cycles == 4'h2)
        else $error("untaken branch timing");
    AST_BRANCH_TAKEN: assert property (
        take && op == 8'h60 && issue_branch_taken |=> (!instr_done) [*2] ##1 instr_done && done_cycles == 4'h3)
        else $error("taken branch timing");
    AST_DIV_EIGHT: assert property (
        take && op == OP_DIV |=> (!issue_ready) [*7] ##1 instr_done && done_cycles == 4'h8)
        else $error("divide timing");
    AST_MAX_EIGHT: assert property (
        instr_done |-> done_cycles inside {[4'h1:4'h8]})
        else $error("cycle count range");
    AST_FLASH_READ: assert property (
        take && op == 8'hE0 && flash_read_enable |=> xdm_rd && xdm_target == 2'h2)
        else $error("flash routing");
    AST_BREAK_HALT: assert property (
        issue_valid && issue_ready && bp_hit |=> halted && halt_cause == 2'h2 && !issue_ready && !instr_done)
        else $error("breakpoint halt");
endmodule
bind cpu_core_instruction_timing cit_chk chk_u (.*);

// ==== mem_model.sv ====
// Behavioural code and data memory answering the core's move strobes
`timescale 1ns/100ps
module mem_model (
    input  wire logic        core_clk,
    input  wire logic        xdm_rd,
    input  wire logic        code_rd,
    input  wire logic [15:0] xdm_addr,
    input  wire logic [15:0] code_addr,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] word_reg;
    logic       live_reg;
    // Outside the read window the bus shows the inverse, so a late sample is caught
    assign mem_rdata = live_reg ? word_reg : ~word_reg;
    always @(posedge core_clk) begin
        live_reg <= xdm_rd || code_rd;
        if (xdm_rd)
            word_reg <= xdm_addr[7:0] ^ xdm_addr[15:8];
        else if (code_rd)
            word_reg <= ~code_addr[7:0];
    end
endmodule

// ==== tb.sv ====
// Bench for the instruction timing core
`timescale 1ns/100ps
module tb;
    import core_timing_pkg::*;
    logic        core_clk, rst_b, issue_valid, issue_branch_taken, flash_read_enable, flash_write_enable;
    logic        dbg_halt_req, dbg_run_req, dbg_step_req, bp_enable, wp_enable, m_cy;
    logic        issue_ready, instr_done, xdm_rd, xdm_wr, code_rd, halted;
    logic [1:0]  done_bytes, xdm_target, halt_cause;
    logic [3:0]  done_cycles;
    logic [7:0]  issue_opcode, issue_operand1, operand_data, mem_rdata, xdm_page, cur_op;
    logic [7:0]  acc, program_status_word, xdm_wdata, m_acc, b;
    logic [15:0] issue_pc, dptr, bp_addr, wp_addr, xdm_addr, code_addr;
    logic [25:0] e, e2;
    logic [25:0] exp_q[$];
    int          n_mismatch, cmp_count, seed, i;

    cpu_core_instruction_timing dut_u (.*);
    mem_model mem_u (.*);

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic final_report(input bit hang);
        n_mismatch += hang;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] want);
        cmp_count++;
        if (got !== want) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic issue(input logic [7:0] op, input logic tk, input logic [15:0] dp, input logic [25:0] x);
        int k;
        @(negedge core_clk);
        for (k = 0; k < 40 && issue_ready !== 1'b1; k++) @(negedge core_clk);
        if (k == 40) final_report(1'b1);
        issue_valid = 1'b1;
        issue_opcode = op;
        issue_operand1 = b;
        operand_data = b;
        issue_branch_taken = tk;
        dptr = dp;
        issue_pc = issue_pc + 16'h1;
        exp_q.push_back(x);
        @(negedge core_clk);
        issue_valid = 1'b0;
    endtask

    function automatic logic [25:0] arith(input int k, input int m);
        logic [8:0] r;
        logic       c, h, v;
        c = k != 0 && m_cy;
        cur_op = (k == 0 ? OP_ADD_BASE : k == 1 ? OP_ADD_WITH_CARRY_BASE : OP_SUBTRACT_WITH_BORROW_BASE)
               + (m < 2 ? 8'(m) : m == 2 ? {7'h01, b[0]} : 8'h04 + b[2:0]);
        r = k == 2 ? {1'b0, m_acc} - b - c : {1'b0, m_acc} + b + c;
        h = k == 2 ? {1'b0, m_acc[3:0]} < b[3:0] + c : {1'b0, m_acc[3:0]} + b[3:0] + c > 5'h0F;
        v = ((m_acc[7] ^ b[7]) == (k == 2)) && r[7] != m_acc[7];
        m_acc = r[7:0];
        m_cy = r[8];
        return {4'h8, m < 2 ? 2'h2 : 2'h1, m == 3 ? 4'h1 : 4'h2, r[7:0], r[8], h, 3'h0, v, 1'b0, ^r[7:0]};
    endfunction

    function automatic logic [25:0] tm(input logic [1:0] t, input logic [1:0] by, input logic [3:0] cy);
        return {1'b0, t != 2'h3, t, by, cy, 16'h0};
    endfunction

    always @(negedge core_clk) begin
        if (instr_done === 1'b1 && exp_q.size() == 0)
            cmp(16'h1, 16'h0);
        else if (instr_done === 1'b1) begin
            e2 = exp_q.pop_front();
            cmp({10'h0, done_bytes, done_cycles}, {10'h0, e2[21:16]});
            if (e2[25]) cmp({acc, program_status_word}, e2[15:0]);
            if (e2[24]) cmp({14'h0, xdm_target}, {14'h0, e2[23:22]});
        end
    end

    initial begin
        seed = 44881;
        {issue_valid, issue_branch_taken, flash_read_enable, flash_write_enable, dbg_halt_req} = '0;
        {dbg_run_req, dbg_step_req, bp_enable, wp_enable, m_cy, n_mismatch, cmp_count} = '0;
        {issue_opcode, issue_operand1, operand_data, xdm_page, m_acc, b} = '0;
        {issue_pc, dptr, bp_addr, wp_addr} = '0;
        rst_b = 1'b0;
        repeat (16) @(negedge core_clk);
        rst_b = 1'b1;
        for (int j = 0; j < 36; j++) begin
            b = $random(seed);
            e = arith(j % 3, j / 3 % 4);
            issue(cur_op, 1'b0, 16'h0, e);
        end
        for (int t = 0; t < 2; t++) begin
            issue(8'h60, t[0], 16'h0, tm(2'h3, 2'h2, 4'h2 + 4'(t)));
            issue(8'hB4, t[0], 16'h0, tm(2'h3, 2'h3, 4'h3 + 4'(t)));
            issue(8'hB6, t[0], 16'h0, tm(2'h3, 2'h3, 4'h4 + 4'(t)));
        end
        issue(OP_DIV, 1'b0, 16'h0, tm(2'h3, 2'h1, 4'h8));
        issue(OP_MUL, 1'b0, 16'h0, tm(2'h3, 2'h1, 4'h4));
        issue(OP_RET, 1'b0, 16'h0, tm(2'h3, 2'h1, 4'h5));
        issue(OP_LJMP, 1'b0, 16'h0, tm(2'h3, 2'h3, 4'h4));
        issue(OP_CODE_MOVE_DP, 1'b0, 16'h2345, tm(2'h3, 2'h1, 4'h3));
        issue(8'hE0, 1'b0, 16'h0FFF, tm(2'h0, 2'h1, 4'h3));
        issue(8'hE0, 1'b0, 16'h1000, tm(2'h1, 2'h1, 4'h3));
        flash_read_enable = 1'b1;
        issue(8'hE0, 1'b0, 16'h1000, tm(2'h2, 2'h1, 4'h3));
        issue(8'hF0, 1'b0, 16'h0FFF, tm(2'h0, 2'h1, 4'h3));
        flash_write_enable = 1'b1;
        issue(8'hF0, 1'b0, 16'hFFFF, tm(2'h2, 2'h1, 4'h3));
        bp_addr = issue_pc + 16'h1;
        bp_enable = 1'b1;
        issue(8'h00, 1'b0, 16'h0, tm(2'h3, 2'h1, 4'h1));
        for (i = 0; i < 20 && halted !== 1'b1; i++) @(negedge core_clk);
        if (i == 20) final_report(1'b1);
        cmp({14'h0, halt_cause}, 16'h2);
        dbg_run_req = 1'b1;
        bp_enable = 1'b0;
        @(negedge core_clk);
        dbg_run_req = 1'b0;
        for (i = 0; i < 40 && exp_q.size() != 0; i++) @(negedge core_clk);
        final_report(exp_q.size() != 0);
    end
endmodule
